//--- hw/usart_pkg.sv
`default_nettype none

package usart_pkg;

   // register byte offsets on the APB side
   localparam logic [11:0] DATA_OFS = 12'h000;
   localparam logic [11:0] CTRL_OFS = 12'h004;

   // baud factor field encodings
   localparam logic [1:0] BAUD_SYNC = 2'h0;
   localparam logic [1:0] BAUD_X1   = 2'h1;
   localparam logic [1:0] BAUD_X16  = 2'h2;
   localparam logic [1:0] BAUD_X64  = 2'h3;

   // stop field encodings (async)
   localparam logic [1:0] STOP_15 = 2'h2;
   localparam logic [1:0] STOP_2  = 2'h3;

   localparam logic [3:0] LEN_BASE   = 4'h5;
   localparam logic [7:0] ONES8      = 8'hFF;
   localparam logic [8:0] ONES9      = 9'h1FF;
   localparam logic [5:0] FAC16_M1   = 6'h0F;
   localparam logic [5:0] FAC64_M1   = 6'h3F;
   localparam logic [5:0] HALF16     = 6'h07;
   localparam logic [5:0] HALF64     = 6'h1F;

   // hi: async stop count; sync: {single sync, external sync}
   typedef struct packed {
      logic [1:0] hi;
      logic       ep;
      logic       pen;
      logic [1:0] len;
      logic [1:0] baud;
   } mode_t;

   typedef struct packed {
      logic hunt;
      logic ireset;
      logic rts;
      logic err_rst;
      logic brk;
      logic rx_en;
      logic dtr;
      logic tx_en;
   } cmd_t;

   typedef struct packed {
      logic dsr;
      logic syn;
      logic fe;
      logic oe;
      logic pe;
      logic txe;
      logic rxr;
      logic txr;
   } status_t;

   typedef struct packed {
      logic [11:0] bits;
      logic [3:0]  n;
   } frame_t;

   localparam mode_t MODE_RST = 8'h00;
   localparam cmd_t  CMD_RST  = 8'h00;

   typedef enum logic [1:0] {
      ST_MODE  = 2'h0,
      ST_SYNC1 = 2'h1,
      ST_SYNC2 = 2'h3,
      ST_CMD   = 2'h2
   } ctl_state_t;

   typedef enum logic [1:0] {
      RX_IDLE  = 2'h0,
      RX_START = 2'h1,
      RX_DATA  = 2'h3,
      RX_STOP  = 2'h2
   } rx_state_t;

endpackage

`default_nettype wire

//--- hw/pin_edges.sv
`default_nettype none

module pin_edges #(
   parameter int W = 1
) (
   // clock and reset
   input  wire logic         pclk,
   input  wire logic         presetn,
   // raw inputs from outside the clock domain
   input  wire logic [W-1:0] din,
   // synchronised level and edge pulses
   output logic      [W-1:0] lvl,
   output logic      [W-1:0] rise,
   output logic      [W-1:0] fall
);
   logic [W-1:0] s1_q;
   logic [W-1:0] s2_q;
   logic [W-1:0] s3_q;

   if (W < 1) begin : g_chk
      $error("pin_edges needs W of at least 1");
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1_q <= '1;
         s2_q <= '1;
         s3_q <= '1;
      end else begin
         s1_q <= din;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   assign lvl  = s2_q;
   assign rise = s2_q & ~s3_q;
   assign fall = ~s2_q & s3_q;

endmodule

`default_nettype wire

//--- hw/usart_ctrl.sv
`default_nettype none

// Overview of operation
// R1: host writes the mode word first after every reset.
// R2: after mode and sync characters, each control write is a command.
// R3: internal-reset command returns to mode expectation; mode fixed otherwise.
// R4: parity excluded from length; received parity never shown on bus.
// R5: short characters sit in low bits; unused bits read zero.
// R6: async frame is start, data lsb first, optional parity, stop bits.
// R7: async bits change on transmit clock falls, bit is 1/16/64 clocks.
// R8: idle line stays high; break command holds it low.
// R9: rx falling edge starts; x16/x64 recheck start at its centre.
// R10: data and parity sampled on rx clock rises; mismatch flags parity.
// R11: only one stop bit checked; low stop flags framing, char kept.
// R12: finished char buffered, available raised; unread char gives overrun.
// R13: error-reset command clears flags; errors never stop the link.
// R14: sync tx idles high until char loaded and clear-to-send low.
// R15: sync underrun sends sync fill, drained high until data written.
// R16: hunt compares first sync each bit; double sync needs second too.
// R17: with parity, sync detect lands at parity bit middle.
// R18: external sync pin high ends hunt; internal detection then off.
// R19: hunt command used in sync mode, ignored in async mode.
// R20: sync rx checks parity even when rx disabled; overrun as async.
// R21: entering hunt fills used receive bits with ones.
// R22: status read clears sync detect; later detect only at boundaries.
// R23: host forces known state with three zero writes and reset command.
// R24: mode, command and status bits use the customary layout.
module usart_ctrl
   import usart_pkg::*;
#(
   parameter int ADDR_W = 12
) (
   // clock and reset
   input  wire logic              pclk,
   input  wire logic              presetn,
   // apb slave
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic [31:0]       pwdata,
   output logic                   pready,
   output logic                   pslverr,
   output logic      [31:0]       prdata,
   // serial link
   input  wire logic              transmit_bit_clock,
   input  wire logic              receive_bit_clock,
   input  wire logic              rxd,
   output logic                   txd,
   // modem control
   input  wire logic              cts_n,
   input  wire logic              dsr_n,
   output logic                   rts_n,
   output logic                   dtr_n,
   // sync detect pin, three-signal form
   input  wire logic              sync_found_pin_i,
   output logic                   sync_found_pin_o,
   output logic                   sync_found_pin_oe,
   // status pins
   output logic                   tx_ready,
   output logic                   transmitter_drained,
   output logic                   receive_char_available
);
   if (ADDR_W < 3 || ADDR_W > 32) begin : g_chk
      $error("usart_ctrl needs ADDR_W between 3 and 32");
   end

   logic [5:0] lvl, rise, fall;
   pin_edges #(.W(6)) u_edges (
      .pclk    (pclk),
      .presetn (presetn),
      .din     ({dsr_n, sync_found_pin_i, cts_n, rxd,
                 receive_bit_clock, transmit_bit_clock}),
      .lvl     (lvl),
      .rise    (rise),
      .fall    (fall)
   );
   logic tx_fall, rx_rise, rxd_l, rxd_fall, cts_l, syn_in_l, dsr_l;
   assign tx_fall  = fall[0];
   assign rx_rise  = rise[1];
   assign rxd_l    = lvl[2];
   assign rxd_fall = fall[2];
   assign cts_l    = lvl[3];
   assign syn_in_l = lvl[4];
   assign dsr_l    = lvl[5];

   // apb decode
   logic acc, setup, is_data, is_ctl, wr_data, wr_ctl, rd_data, rd_stat;
   assign acc   = psel & penable;
   assign setup = psel & ~penable;
   always_comb begin
      is_data = 1'b0;
      is_ctl  = 1'b0;
      if (paddr == ADDR_W'(DATA_OFS)) begin
         is_data = 1'b1;
      end else if (paddr == ADDR_W'(CTRL_OFS)) begin
         is_ctl = 1'b1;
      end
   end
   assign wr_data = acc & pwrite & is_data;
   assign wr_ctl  = acc & pwrite & is_ctl;
   assign rd_data = acc & ~pwrite & is_data;
   assign rd_stat = acc & ~pwrite & is_ctl;
   assign pready  = 1'b1;
   assign pslverr = acc & ~is_data & ~is_ctl;

   // control word sequencing
   ctl_state_t st_q;
   mode_t      mode_q;
   cmd_t       cmd_q;
   logic [7:0] sync1_q, sync2_q;
   logic       is_sync, soft_rst, err_clr, hunt_cmd;
   cmd_t       cw;
   assign cw       = cmd_t'(pwdata[7:0]);
   assign is_sync  = (mode_q.baud == BAUD_SYNC);
   assign soft_rst = wr_ctl & (st_q == ST_CMD) & cw.ireset;   // R3
   assign err_clr  = wr_ctl & (st_q == ST_CMD) & cw.err_rst;
   assign hunt_cmd = wr_ctl & (st_q == ST_CMD) & cw.hunt & is_sync; // R19

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q    <= ST_MODE;
         mode_q  <= MODE_RST;
         cmd_q   <= CMD_RST;
         sync1_q <= 8'h00;
         sync2_q <= 8'h00;
      end else if (soft_rst) begin
         st_q  <= ST_MODE;                                      // R3
         cmd_q <= CMD_RST;
      end else if (wr_ctl) begin
         case (st_q)
            ST_MODE: begin
               mode_q <= mode_t'(pwdata[7:0]);                  // R3
               st_q   <= (pwdata[1:0] == BAUD_SYNC) ? ST_SYNC1 : ST_CMD;
            end
            ST_SYNC1: begin
               sync1_q <= pwdata[7:0];
               st_q    <= mode_q.hi[1] ? ST_CMD : ST_SYNC2;
            end
            ST_SYNC2: begin
               sync2_q <= pwdata[7:0];
               st_q    <= ST_CMD;
            end
            default: begin
               cmd_q         <= cw;                             // R2
               cmd_q.err_rst <= 1'b0;
               cmd_q.hunt    <= 1'b0;
            end
         endcase
      end
   end

   // character geometry
   logic [3:0] nd, nb;
   logic [7:0] dmask;
   logic [5:0] fac_m1, half;
   assign nd    = {2'b00, mode_q.len} + LEN_BASE;
   assign nb    = nd + {3'b000, mode_q.pen};                   // R4
   assign dmask = ONES8 >> (4'd8 - nd);
   always_comb begin
      case (mode_q.baud)                                        // R7
         BAUD_X16: begin fac_m1 = FAC16_M1; half = HALF16; end
         BAUD_X64: begin fac_m1 = FAC64_M1; half = HALF64; end
         default:  begin fac_m1 = 6'h00;    half = 6'h00;  end
      endcase
   end

   function automatic frame_t mk_frame(input logic [7:0] d,
                                       input mode_t m, input logic sy);
      frame_t     f;
      logic [3:0] n;
      logic [3:0] p;
      logic       par;
      f.bits = '1;
      n   = {2'b00, m.len} + LEN_BASE;
      p   = sy ? 4'd0 : 4'd1;
      par = ~m.ep;
      if (!sy) f.bits[0] = 1'b0;                                // R6
      for (int i = 0; i < 8; i++) begin
         if (4'(i) < n) begin
            f.bits[4'(i) + p] = d[i];                           // R6
            par = par ^ d[i];
         end
      end
      if (m.pen) f.bits[n + p] = par;                           // R6
      f.n = n + p + {3'b000, m.pen};
      if (!sy) f.n = f.n + ((m.hi == STOP_2) ? 4'd2 : 4'd1);
      return f;
   endfunction

   // transmit holding register
   logic [7:0] tx_hold_q;
   logic       tx_full_q, tx_take;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_full_q <= 1'b0;
         tx_hold_q <= 8'h00;
      end else if (soft_rst) begin
         tx_full_q <= 1'b0;
      end else if (wr_data) begin
         tx_full_q <= 1'b1;
         tx_hold_q <= pwdata[7:0] & dmask;                      // R5
      end else if (tx_take) begin
         tx_full_q <= 1'b0;
      end
   end

   // transmit shifter
   logic [11:0] tx_sr_q;
   logic [3:0]  tx_left_q;
   logic [6:0]  tx_cnt_q, tx_lim;
   logic        tx_busy_q, txd_q, tx_fill_q, tx_started_q, tx_sel_q;
   logic        bit_end, frame_end;
   frame_t      fr_data, fr_fill;
   assign fr_data = mk_frame(tx_hold_q, mode_q, is_sync);
   assign fr_fill = mk_frame(tx_sel_q ? sync2_q : sync1_q, mode_q, is_sync);
   always_comb begin
      tx_lim = {1'b0, fac_m1};
      if (!is_sync && mode_q.hi == STOP_15 && tx_left_q == 4'd1) begin
         tx_lim = {1'b0, fac_m1} + {1'b0, half} + 7'd1;
      end
   end
   assign bit_end   = (tx_cnt_q == tx_lim);
   assign frame_end = ~tx_busy_q | (bit_end & (tx_left_q == 4'd1));
   assign tx_take   = tx_fall & frame_end & tx_full_q
                      & cmd_q.tx_en & ~cts_l;                   // R14

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_sr_q <= '1;  tx_left_q <= 4'd0;  tx_cnt_q <= 7'd0;
         tx_busy_q <= 1'b0;  txd_q <= 1'b1;  tx_fill_q <= 1'b0;
         tx_started_q <= 1'b0;  tx_sel_q <= 1'b0;
      end else if (soft_rst) begin
         tx_sr_q <= '1;  tx_left_q <= 4'd0;  tx_cnt_q <= 7'd0;
         tx_busy_q <= 1'b0;  txd_q <= 1'b1;  tx_fill_q <= 1'b0;
         tx_started_q <= 1'b0;  tx_sel_q <= 1'b0;
      end else if (tx_fall) begin                               // R7
         if (tx_busy_q && !bit_end) begin
            tx_cnt_q <= tx_cnt_q + 7'd1;
         end else if (!frame_end) begin
            tx_cnt_q  <= 7'd0;
            txd_q     <= tx_sr_q[0];                            // R6
            tx_sr_q   <= {1'b1, tx_sr_q[11:1]};
            tx_left_q <= tx_left_q - 4'd1;
         end else if (tx_take) begin
            txd_q        <= fr_data.bits[0];
            tx_sr_q      <= {1'b1, fr_data.bits[11:1]};
            tx_left_q    <= fr_data.n;
            tx_cnt_q     <= 7'd0;
            tx_busy_q    <= 1'b1;
            tx_fill_q    <= 1'b0;
            tx_started_q <= 1'b1;
            tx_sel_q     <= 1'b0;
         end else if (is_sync && tx_started_q) begin
            txd_q     <= fr_fill.bits[0];                       // R15
            tx_sr_q   <= {1'b1, fr_fill.bits[11:1]};
            tx_left_q <= fr_fill.n;
            tx_cnt_q  <= 7'd0;
            tx_busy_q <= 1'b1;
            tx_fill_q <= 1'b1;
            tx_sel_q  <= ~tx_sel_q & ~mode_q.hi[1];
         end else begin
            tx_busy_q <= 1'b0;
            txd_q     <= 1'b1;                                  // R8
         end
      end
   end

   assign txd                 = cmd_q.brk ? 1'b0 : txd_q;       // R8
   assign tx_ready            = ~tx_full_q & cmd_q.tx_en & ~cts_l;
   assign transmitter_drained = ~tx_full_q & (~tx_busy_q | tx_fill_q); // R15

   // receiver
   rx_state_t  rx_st_q;
   logic [6:0] rx_cnt_q;
   logic [3:0] rx_idx_q;
   logic [8:0] rx_bits_q, rx_sh_q, sh_n, al, rx_word_q;
   logic       armed_q, hunt_q, hstage_q, prev_s1_q;
   logic       rx_done_q, rx_fe_q, rx_syn_q, ext_sync, dat_s1, dat_s2;
   assign ext_sync = is_sync & mode_q.hi[0];
   assign sh_n     = {rxd_l, rx_sh_q[8:1]};
   assign al       = sh_n >> (4'd9 - nb);
   assign dat_s1   = ((al[7:0] & dmask) == (sync1_q & dmask));
   assign dat_s2   = ((al[7:0] & dmask) == (sync2_q & dmask));

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_st_q <= RX_IDLE;  rx_cnt_q <= 7'd0;  rx_idx_q <= 4'd0;
         rx_bits_q <= ONES9;  rx_sh_q <= ONES9;  rx_word_q <= 9'h000;
         armed_q <= 1'b0;  hunt_q <= 1'b1;  hstage_q <= 1'b0;
         prev_s1_q <= 1'b0;  rx_done_q <= 1'b0;  rx_fe_q <= 1'b0;
         rx_syn_q <= 1'b0;
      end else if (soft_rst) begin
         rx_st_q <= RX_IDLE;  rx_cnt_q <= 7'd0;  rx_idx_q <= 4'd0;
         rx_bits_q <= ONES9;  rx_sh_q <= ONES9;
         armed_q <= 1'b0;  hunt_q <= 1'b1;  hstage_q <= 1'b0;
         prev_s1_q <= 1'b0;  rx_done_q <= 1'b0;  rx_fe_q <= 1'b0;
         rx_syn_q <= 1'b0;
      end else begin
         rx_done_q <= 1'b0;
         rx_syn_q  <= 1'b0;
         if (hunt_cmd) begin
            hunt_q   <= 1'b1;
            hstage_q <= 1'b0;
            rx_sh_q  <= ONES9;                                  // R21
         end else if (is_sync) begin
            if (rx_rise) begin                                  // R10
               rx_sh_q <= sh_n;
               if (ext_sync && syn_in_l) begin
                  rx_syn_q <= 1'b1;                             // R18
                  if (hunt_q) begin
                     hunt_q   <= 1'b0;
                     rx_idx_q <= 4'd0;
                  end
               end
               if (hunt_q && !ext_sync) begin
                  if (!hstage_q) begin
                     if (dat_s1) begin                          // R16
                        rx_idx_q <= 4'd0;
                        if (mode_q.hi[1]) begin
                           hunt_q   <= 1'b0;
                           rx_syn_q <= 1'b1;                    // R17
                        end else begin
                           hstage_q <= 1'b1;
                        end
                     end
                  end else if (rx_idx_q == nb - 4'd1) begin
                     rx_idx_q <= 4'd0;
                     hstage_q <= 1'b0;
                     if (dat_s2) begin                          // R16
                        hunt_q   <= 1'b0;
                        rx_syn_q <= 1'b1;
                     end
                  end else begin
                     rx_idx_q <= rx_idx_q + 4'd1;
                  end
               end else if (!hunt_q) begin
                  if (rx_idx_q == nb - 4'd1) begin
                     rx_idx_q  <= 4'd0;
                     rx_done_q <= 1'b1;                         // R20
                     rx_word_q <= al;
                     prev_s1_q <= dat_s1;
                     if (!ext_sync && (mode_q.hi[1] ? dat_s1
                                       : prev_s1_q & dat_s2)) begin
                        rx_syn_q <= 1'b1;                       // R22
                     end
                  end else begin
                     rx_idx_q <= rx_idx_q + 4'd1;
                  end
               end
            end
         end else begin
            if (rxd_l) armed_q <= 1'b1;
            case (rx_st_q)
               RX_IDLE: begin
                  if (rxd_fall && armed_q) begin                // R9
                     rx_cnt_q <= 7'd0;
                     rx_idx_q <= 4'd0;
                     rx_st_q  <= RX_START;
                  end
               end
               RX_START: begin
                  if (rx_rise) begin
                     if (rx_cnt_q == {1'b0, half}) begin
                        rx_cnt_q <= 7'd0;
                        // x1 only waits out the start centre rise
                        rx_st_q  <= (rxd_l && mode_q.baud != BAUD_X1)
                                    ? RX_IDLE : RX_DATA;        // R9
                     end else begin
                        rx_cnt_q <= rx_cnt_q + 7'd1;
                     end
                  end
               end
               RX_DATA: begin
                  if (rx_rise) begin
                     if (rx_cnt_q == {1'b0, fac_m1}) begin
                        rx_cnt_q <= 7'd0;
                        rx_bits_q[rx_idx_q] <= rxd_l;           // R10
                        if (rx_idx_q == nb - 4'd1) begin
                           rx_st_q <= RX_STOP;
                        end else begin
                           rx_idx_q <= rx_idx_q + 4'd1;
                        end
                     end else begin
                        rx_cnt_q <= rx_cnt_q + 7'd1;
                     end
                  end
               end
               default: begin
                  if (rx_rise) begin
                     if (rx_cnt_q == {1'b0, fac_m1}) begin
                        rx_cnt_q  <= 7'd0;
                        rx_fe_q   <= ~rxd_l;                    // R11
                        rx_done_q <= 1'b1;
                        rx_word_q <= rx_bits_q;
                        rx_st_q   <= RX_IDLE;
                     end else begin
                        rx_cnt_q <= rx_cnt_q + 7'd1;
                     end
                  end
               end
            endcase
         end
      end
   end

   // receive buffer and flags
   logic [7:0] rx_buf_q;
   logic       avail_q, pe_q, oe_q, fe_q, syn_q, par_bad;
   assign par_bad = mode_q.pen &
                    (^{rx_word_q[7:0] & dmask, rx_word_q[nd]} == mode_q.ep);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_buf_q <= 8'h00;
         avail_q  <= 1'b0;
         pe_q     <= 1'b0;
         oe_q     <= 1'b0;
         fe_q     <= 1'b0;
      end else if (soft_rst) begin
         avail_q <= 1'b0;
         pe_q    <= 1'b0;
         oe_q    <= 1'b0;
         fe_q    <= 1'b0;
      end else begin
         if (err_clr) begin                                     // R13
            pe_q <= 1'b0;
            oe_q <= 1'b0;
            fe_q <= 1'b0;
         end
         if (rd_data) avail_q <= 1'b0;
         if (rx_done_q) begin
            rx_buf_q <= rx_word_q[7:0] & dmask;                 // R4
            if (par_bad) pe_q <= 1'b1;                          // R10
            if (rx_fe_q && !is_sync) fe_q <= 1'b1;              // R11
            if (avail_q) oe_q <= 1'b1;                          // R12
            avail_q <= 1'b1;                                    // R12
         end
         if (!cmd_q.rx_en) avail_q <= 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         syn_q <= 1'b0;
      end else if (soft_rst) begin
         syn_q <= 1'b0;
      end else if (rx_syn_q) begin
         syn_q <= 1'b1;
      end else if (rd_stat) begin
         syn_q <= 1'b0;                                         // R22
      end
   end

   assign receive_char_available = avail_q;
   assign sync_found_pin_o       = syn_q;
   assign sync_found_pin_oe      = ~ext_sync;                   // R18
   assign rts_n                  = ~cmd_q.rts;
   assign dtr_n                  = ~cmd_q.dtr;

   // read data captured in the setup phase
   status_t st_w;
   logic [31:0] prdata_q;
   always_comb begin
      st_w     = '0;                                            // R24
      st_w.txr = ~tx_full_q;
      st_w.rxr = avail_q;
      st_w.txe = transmitter_drained;
      st_w.pe  = pe_q;
      st_w.oe  = oe_q;
      st_w.fe  = fe_q;
      st_w.syn = syn_q;
      st_w.dsr = ~dsr_l;
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q <= 32'h0000_0000;
      end else if (setup && (!pwrite || (!is_data && !is_ctl))) begin
         if (is_data) begin
            prdata_q <= {24'h000000, rx_buf_q};                 // R5
         end else if (is_ctl) begin
            prdata_q <= {24'h000000, st_w};
         end else begin
            prdata_q <= 32'h0000_0000;
         end
      end
   end
   assign prdata = prdata_q;

endmodule

`default_nettype wire

//--- tb/usart_chk.sv
`default_nettype none
module usart_chk (
   // apb side
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic [31:0] prdata,
   // link side
   input wire logic        transmit_bit_clock,
   input wire logic        cts_n,
   input wire logic        txd,
   input wire logic        tx_ready,
   input wire logic        transmitter_drained,
   input wire logic        receive_char_available
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence acc; psel && penable; endsequence
   sequence dwr; psel && penable && pwrite && paddr == 12'h000; endsequence
   sequence drd; psel && penable && !pwrite && paddr == 12'h000; endsequence
   a_zero_wait: assert property (acc |-> pready)
      else $error("access without ready");
   a_high_zero: assert property (psel && penable && !pwrite |->
      prdata[31:8] == 24'h000000) else $error("upper read bits set");
   a_bad_addr: assert property (psel && penable && paddr != 12'h000 &&
      paddr != 12'h004 |-> pslverr && prdata == 32'h0)
      else $error("unmapped access not refused");
   a_cts_gate: assert property (tx_ready |-> !$past(cts_n, 2))
      else $error("ready without clear to send");
   a_read_clears: assert property (drd |=> !receive_char_available)
      else $error("available kept after read");
   a_write_fills: assert property (dwr |=> !transmitter_drained)
      else $error("drained kept after data write");
   a_drain_cause: assert property ($fell(transmitter_drained) |->
      $past(psel && penable && pwrite && paddr == 12'h000))
      else $error("drained fell without data write");
   a_tx_on_fall: assert property ($changed(txd) |->
      !$past(transmit_bit_clock, 2)) else $error("txd moved off clock fall");
endmodule
bind usart_ctrl usart_chk i_usart_chk (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pready(pready), .pslverr(pslverr), .prdata(prdata), .txd(txd),
   .transmit_bit_clock(transmit_bit_clock), .cts_n(cts_n),
   .tx_ready(tx_ready), .transmitter_drained(transmitter_drained),
   .receive_char_available(receive_char_available));
`default_nettype wire

//--- tb/serial_peer.sv
`default_nettype none
module serial_peer (
   // serial side
   input  wire logic txd,
   input  wire logic cts_hold,
   output logic      rxd,
   output logic      bit_clk,
   output logic      cts_n,
   output logic      dsr_n
);
   timeunit 1ns;
   timeprecision 100ps;
   // echoing terminal, free running baud source
   assign rxd = txd;
   assign cts_n = cts_hold;
   assign dsr_n = 1'b0;
   initial begin
      bit_clk = 1'b1;
      #3;
      forever #40 bit_clk = ~bit_clk;
   end
endmodule
`default_nettype wire

//--- tb/test_usart_ctrl.sv
`default_nettype none
module test_usart_ctrl import usart_pkg::*; ;
   timeunit 1ns;
   timeprecision 100ps;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, r;
   logic pready, pslverr, txd, rxd, bclk, cts_n, dsr_n, rts_n, dtr_n;
   logic sf_o, sf_oe, tx_ready, drained, avail, err, cts_hold = 0;
   int failures = 0, tests_run = 0;
   always #5 pclk = ~pclk;
   usart_ctrl i_usart_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pready(pready), .pslverr(pslverr), .prdata(prdata),
      .transmit_bit_clock(bclk), .receive_bit_clock(bclk), .rxd(rxd),
      .txd(txd), .cts_n(cts_n), .dsr_n(dsr_n), .rts_n(rts_n), .dtr_n(dtr_n),
      .sync_found_pin_i(sf_oe & sf_o), .sync_found_pin_o(sf_o),
      .sync_found_pin_oe(sf_oe), .tx_ready(tx_ready),
      .transmitter_drained(drained), .receive_char_available(avail));
   serial_peer i_serial_peer (.txd(txd), .rxd(rxd), .bit_clk(bclk),
      .cts_hold(cts_hold), .cts_n(cts_n), .dsr_n(dsr_n));
   task automatic xfer(input logic w, input logic [11:0] a,
                       input logic [7:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      r = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic chk(input logic [8:0] g, input logic [8:0] e);
      tests_run++;
      if (g !== e) begin
         failures++;
         $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic rx_check(input logic [7:0] d, input logic [7:0] e);
      xfer(1, DATA_OFS, d);
      for (int i = 0; i < 300 && avail !== 1'b1; i++)
         @(posedge pclk);
      xfer(0, CTRL_OFS, 0);
      chk(r[5:1], 5'h01);
      xfer(0, DATA_OFS, 0);
      chk(r[7:0], e);
   endtask
   task automatic t_frame;
      xfer(1, CTRL_OFS, 8'h4D);
      xfer(1, CTRL_OFS, 8'h37);
      rx_check(8'hA5, 8'hA5);
      $display("frame test done");
   endtask
   task automatic t_overrun;
      xfer(1, DATA_OFS, 8'h3C);
      @(posedge pclk);
      for (int i = 0; i < 300 && tx_ready !== 1'b1; i++)
         @(posedge pclk);
      xfer(1, DATA_OFS, 8'hC3);
      r = 0;
      for (int i = 0; i < 70 && r[4] !== 1'b1; i++)
         xfer(0, CTRL_OFS, 0);
      chk(r[4], 1'b1);
      xfer(0, DATA_OFS, 0);
      chk(r[7:0], 8'hC3);
      xfer(1, CTRL_OFS, 8'h37);
      xfer(0, CTRL_OFS, 0);
      chk(r[4], 1'b0);
      $display("overrun test done");
   endtask
   task automatic t_short;
      cts_hold <= 1'b1;
      repeat (4) @(posedge pclk);
      chk(tx_ready, 1'b0);
      cts_hold <= 1'b0;
      repeat (4) @(posedge pclk);
      chk(tx_ready, 1'b1);
      xfer(1, CTRL_OFS, 8'h40);
      @(posedge pclk);
      chk({dtr_n, rts_n}, 8'h03);
      xfer(1, CTRL_OFS, 8'h71);
      xfer(1, CTRL_OFS, 8'hB7);
      rx_check(8'hFF, 8'h1F);
      xfer(0, 12'h008, 0);
      chk({err, r[7:0]}, 9'h100);
      $display("short char test done");
   endtask
   task automatic close_out;
      $display("comparisons %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < 4; i++)
         xfer(1, CTRL_OFS, i == 3 ? 8'h40 : 8'h00);
      t_frame();
      t_overrun();
      t_short();
      close_out();
   end
   initial begin
      #100us;
      failures++;
      close_out();
   end
endmodule
`default_nettype wire
